// ### hw/pll_latch_defs.vh
// Purpose: Constants for the dual synthesizer serial latch control
// Assumes: 24-bit words, latch select in the two lowest bits
// Notes:   Field positions are bit indices within the latched word
`ifndef PLL_LATCH_DEFS_VH
`define PLL_LATCH_DEFS_VH

`define WORD_BITS        24
`define SEL_IF_REF       2'h0
`define SEL_IF_FB        2'h1
`define SEL_RF_REF       2'h2
`define SEL_RF_FB        2'h3
// Feedback latch fields
`define FB_GAIN_BIT      23
`define FB_PD_BIT        22
`define FB_PRE_HI        21
`define FB_PRE_LO        20
`define FB_MAIN_HI       19
`define FB_MAIN_LO       8
`define FB_SWAL_HI       7
`define FB_SWAL_LO       2
// Reference latch fields
`define RF_CUR_HI        23
`define RF_CUR_LO        21
`define REF_OUTSEL_HI    20
`define REF_OUTSEL_LO    19
`define REF_TRI_BIT      18
`define REF_POL_BIT      17
`define REF_DIV_HI       16
`define REF_DIV_LO       2
// Output select mode codes (high, low)
`define MUX_LOCK_IF      4'h1
`define MUX_LOCK_RF      4'h2
`define MUX_LOCK_BOTH    4'h3
`define MUX_FASTLOCK     4'h4
`define MUX_RST_IF       4'h5
`define MUX_RST_RF       4'h6
`define MUX_RST_BOTH     4'h7
// Pump current code used while in fastlock
`define CUR_MAX          3'h7
// Cycles of pump three-state before a synchronous power-down completes
`define SYNC_PD_CYCLES   2'h2

`endif

// ### hw/pll_serial_latch.v
// Purpose: Serial word capture, four latches and decoded control of a dual synthesizer
// Assumes: Serial clock, data and load strobe are asynchronous, sampled by sys_clk
// Notes:   Analog loops are outside; lock indications arrive as inputs
`timescale 1ns/1ps
`default_nettype none
`include "pll_latch_defs.vh"

module pll_serial_latch (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // Three-wire serial link
  input  wire        serialClk,
  input  wire        serialData,
  input  wire        load_strobe,
  // Lock indications from the loops
  input  wire        ifLocked,
  input  wire        rfLocked,
  // IF section controls
  output reg  [14:0] ifRefDivide,
  output reg  [11:0] ifMainDivide,
  output reg  [5:0]  ifSwallowDivide,
  output reg  [1:0]  ifPrescaleSel,
  output reg  [2:0]  ifPumpCurrent,
  output reg         if_pd_polarity,
  output reg         ifPumpHighZ,
  output reg         ifPoweredDown,
  output reg         ifDividerHold,
  // RF section controls
  output reg  [14:0] rfRefDivide,
  output reg  [11:0] rfMainDivide,
  output reg  [5:0]  rfSwallowDivide,
  output reg  [1:0]  rfPrescaleSel,
  output reg  [2:0]  rfPumpCurrent,
  output reg         rf_pd_polarity,
  output reg         rfPumpHighZ,
  output reg         rfPoweredDown,
  output reg         rfDividerHold,
  // Shared outputs
  output reg         refOscEnable,
  output reg         fastlock_switch_pin_b,
  output reg         rfDampSwitch,
  output reg         multiplexed_test_output
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  reg  [2:0]  sclkSync_reg;
  reg  [2:0]  leSync_reg;
  reg  [1:0]  dataSync_reg;
  wire        sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2];
  wire        leRise   = leSync_reg[1] & ~leSync_reg[2];

  // Two flops before any logic; third flop holds the previous level
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkSync_reg <= 3'h0;
      leSync_reg   <= 3'h0;
      dataSync_reg <= 2'h0;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], serialClk};
      leSync_reg   <= {leSync_reg[1:0], load_strobe};
      dataSync_reg <= {dataSync_reg[0], serialData};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and latches
  reg  [23:0] shift_reg;
  reg  [23:0] ifRefLatch_reg;
  reg  [23:0] ifFbLatch_reg;
  reg  [23:0] rfRefLatch_reg;
  reg  [23:0] rfFbLatch_reg;

  // Never gated by power-down, so words keep loading in every mode
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg      <= 24'h000000;
      ifRefLatch_reg <= 24'h000000;
      ifFbLatch_reg  <= 24'h000000;
      rfRefLatch_reg <= 24'h000000;
      rfFbLatch_reg  <= 24'h000000;
    end else begin
      if (sclkRise)
        shift_reg <= {shift_reg[22:0], dataSync_reg[1]};  // MSB first
      // Partial words simply sit until overwritten
      if (leRise) begin
        case (shift_reg[1:0])
          `SEL_IF_REF: ifRefLatch_reg <= shift_reg;
          `SEL_IF_FB:  ifFbLatch_reg  <= shift_reg;
          `SEL_RF_REF: rfRefLatch_reg <= shift_reg;
          `SEL_RF_FB:  rfFbLatch_reg  <= shift_reg;
          default:     rfFbLatch_reg  <= rfFbLatch_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire [3:0] muxMode = {ifRefLatch_reg[`REF_OUTSEL_HI:`REF_OUTSEL_LO],
                        rfRefLatch_reg[`REF_OUTSEL_HI:`REF_OUTSEL_LO]};
  wire ifTriBit  = ifRefLatch_reg[`REF_TRI_BIT];
  wire rfTriBit  = rfRefLatch_reg[`REF_TRI_BIT];
  wire ifPdBit   = ifFbLatch_reg[`FB_PD_BIT];
  wire rfPdBit   = rfFbLatch_reg[`FB_PD_BIT];
  wire ifFast    = ifFbLatch_reg[`FB_GAIN_BIT];
  wire rfFast    = rfFbLatch_reg[`FB_GAIN_BIT];
  wire ifCntRst  = (muxMode == `MUX_RST_IF) | (muxMode == `MUX_RST_BOTH);
  wire rfCntRst  = (muxMode == `MUX_RST_RF) | (muxMode == `MUX_RST_BOTH);

  ////////////////////////////////////////////////////////////////////////////
  // Power-down sequencing
  reg  [1:0] ifPdCnt_reg;
  reg  [1:0] rfPdCnt_reg;
  reg        ifPdState_reg;
  reg        rfPdState_reg;
  reg  [1:0] ifPdCnt_next;
  reg  [1:0] rfPdCnt_next;
  reg        ifPdState_next;
  reg        rfPdState_next;

  // Tristate bit set: power down at once; else float pump, then wait
  always @* begin
    ifPdState_next = ifPdState_reg;
    ifPdCnt_next   = ifPdCnt_reg;
    if (!ifPdBit) begin
      ifPdState_next = 1'b0;
      ifPdCnt_next   = 2'h0;
    end else if (!ifPdState_reg) begin
      if (ifTriBit)
        ifPdState_next = 1'b1;
      else if (ifPdCnt_reg == `SYNC_PD_CYCLES)
        ifPdState_next = 1'b1;
      else
        ifPdCnt_next = ifPdCnt_reg + 2'h1;
    end
    rfPdState_next = rfPdState_reg;
    rfPdCnt_next   = rfPdCnt_reg;
    if (!rfPdBit) begin
      rfPdState_next = 1'b0;
      rfPdCnt_next   = 2'h0;
    end else if (!rfPdState_reg) begin
      if (rfTriBit)
        rfPdState_next = 1'b1;
      else if (rfPdCnt_reg == `SYNC_PD_CYCLES)
        rfPdState_next = 1'b1;
      else
        rfPdCnt_next = rfPdCnt_reg + 2'h1;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ifPdCnt_reg   <= 2'h0;
      rfPdCnt_reg   <= 2'h0;
      ifPdState_reg <= 1'b0;
      rfPdState_reg <= 1'b0;
    end else begin
      ifPdCnt_reg   <= ifPdCnt_next;
      rfPdCnt_reg   <= rfPdCnt_next;
      ifPdState_reg <= ifPdState_next;
      rfPdState_reg <= rfPdState_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output multiplexer selection
  reg multiplexed_test_output_next;

  // Lock modes pass the loop lock level; combined mode needs both loops
  always @* begin
    case (muxMode)
      `MUX_LOCK_IF:   multiplexed_test_output_next = ifLocked;
      `MUX_LOCK_RF:   multiplexed_test_output_next = rfLocked;
      `MUX_LOCK_BOTH: multiplexed_test_output_next = ifLocked & rfLocked;
      `MUX_FASTLOCK:  multiplexed_test_output_next = ~rfRefLatch_reg[`REF_OUTSEL_HI];  // Low grounds
      default:        multiplexed_test_output_next = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ifRefDivide             <= 15'h0000;
      ifMainDivide            <= 12'h000;
      ifSwallowDivide         <= 6'h00;
      ifPrescaleSel           <= 2'h0;
      ifPumpCurrent           <= 3'h0;
      if_pd_polarity          <= 1'b0;
      ifPumpHighZ             <= 1'b1;
      ifPoweredDown           <= 1'b0;
      ifDividerHold           <= 1'b0;
      rfRefDivide             <= 15'h0000;
      rfMainDivide            <= 12'h000;
      rfSwallowDivide         <= 6'h00;
      rfPrescaleSel           <= 2'h0;
      rfPumpCurrent           <= 3'h0;
      rf_pd_polarity          <= 1'b0;
      rfPumpHighZ             <= 1'b1;
      rfPoweredDown           <= 1'b0;
      rfDividerHold           <= 1'b0;
      refOscEnable            <= 1'b1;
      fastlock_switch_pin_b   <= 1'b1;
      rfDampSwitch            <= 1'b0;
      multiplexed_test_output <= 1'b0;
    end else begin
      ifRefDivide     <= ifRefLatch_reg[`REF_DIV_HI:`REF_DIV_LO];
      rfRefDivide     <= rfRefLatch_reg[`REF_DIV_HI:`REF_DIV_LO];
      ifMainDivide    <= ifFbLatch_reg[`FB_MAIN_HI:`FB_MAIN_LO];
      ifSwallowDivide <= ifFbLatch_reg[`FB_SWAL_HI:`FB_SWAL_LO];
      rfMainDivide    <= rfFbLatch_reg[`FB_MAIN_HI:`FB_MAIN_LO];
      rfSwallowDivide <= rfFbLatch_reg[`FB_SWAL_HI:`FB_SWAL_LO];
      ifPrescaleSel   <= ifFbLatch_reg[`FB_PRE_HI:`FB_PRE_LO];
      rfPrescaleSel   <= rfFbLatch_reg[`FB_PRE_HI:`FB_PRE_LO];
      // Fastlock overrides the programmed current with the maximum
      ifPumpCurrent   <= ifFast ? `CUR_MAX
                                : ifRefLatch_reg[`RF_CUR_HI:`RF_CUR_LO];
      rfPumpCurrent   <= rfFast ? `CUR_MAX
                                : rfRefLatch_reg[`RF_CUR_HI:`RF_CUR_LO];
      if_pd_polarity  <= ifRefLatch_reg[`REF_POL_BIT];
      rf_pd_polarity  <= rfRefLatch_reg[`REF_POL_BIT];
      // Pump floats for the tristate bit, a pending power-down, or a reset mode
      ifPumpHighZ     <= ifTriBit | ifPdBit | ifCntRst;
      rfPumpHighZ     <= rfTriBit | rfPdBit | rfCntRst;
      ifPoweredDown   <= ifPdState_next;
      rfPoweredDown   <= rfPdState_next;
      // Dividers held in load; release restarts them together, keeping alignment
      ifDividerHold   <= ifPdState_next | ifCntRst;
      rfDividerHold   <= rfPdState_next | rfCntRst;
      refOscEnable    <= ~(ifPdState_next & rfPdState_next);
      fastlock_switch_pin_b <= ~ifFast;
      rfDampSwitch    <= rfFast;
      multiplexed_test_output <= multiplexed_test_output_next;
    end
  end

endmodule // pll_serial_latch
`default_nettype wire

// ### verif/dual_pll_serial_latch_control_bench.sv
// Purpose: Self-checking bench of the serial latch block
// Assumes: Host model shifts words at a 48 ns link period
// Notes:   Random words keep gain, power-down and mode bits clear
`timescale 1ns/1ps
`default_nettype none
module dual_pll_serial_latch_control_bench;
  logic sys_clk = 1'b0, rst_b = 1'b0, ifLocked = 1'b0, rfLocked = 1'b0;
  wire serialClk, serialData, load_strobe, if_pd_polarity, rf_pd_polarity;
  wire [14:0] ifRefDivide, rfRefDivide;
  wire [11:0] ifMainDivide, rfMainDivide;
  wire [5:0] ifSwallowDivide, rfSwallowDivide;
  wire [2:0] ifPumpCurrent, rfPumpCurrent;
  wire [1:0] ifPrescaleSel, rfPrescaleSel;
  wire ifPumpHighZ, rfPumpHighZ, ifPoweredDown, rfPoweredDown, ifDividerHold, rfDividerHold;
  wire refOscEnable, fastlock_switch_pin_b, rfDampSwitch, multiplexed_test_output;
  int err_total = 0, check_count = 0, cycles = 0;
  logic [21:0] q[$];
  logic [21:0] note;
  logic [23:0] w;
  event got;
  pll_serial_latch i_dut (.*);
  serial_host_model i_host (.sClk(serialClk), .sData(serialData), .strobe(load_strobe));
  always #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Send a word; fb words note 21..2, ref words 23..21 and 18..2
  task automatic wr(input logic [23:0] x, input bit n);
    @(posedge sys_clk) #1;
    i_host.send(x, 24);
    repeat (3) @(posedge sys_clk);
    if (n) begin
      q.push_back({x[1:0], x[0] ? x[21:2] : {x[23:21], x[18:2]}});
      -> got;
    end
  endtask
  // Oldest note against the latch it names
  always @(got) begin
    note = q.pop_front();
    case (note[21:20])
      2'h0: chk({4'h0, ifPumpCurrent, ifPumpHighZ, if_pd_polarity, ifRefDivide}, {4'h0, note[19:0]});
      2'h1: chk({4'h0, ifPrescaleSel, ifMainDivide, ifSwallowDivide}, {4'h0, note[19:0]});
      2'h2: chk({4'h0, rfPumpCurrent, rfPumpHighZ, rf_pd_polarity, rfRefDivide}, {4'h0, note[19:0]});
      default: chk({4'h0, rfPrescaleSel, rfMainDivide, rfSwallowDivide}, {4'h0, note[19:0]});
    endcase
  end
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0139E56D));
    repeat (4) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    @(posedge sys_clk) #1;
    chk({6'h0, refOscEnable, fastlock_switch_pin_b, ifPoweredDown, ifRefDivide}, 24'h30000);
    for (int i = 0; i < 16; i++) begin
      w = $urandom();
      w[1:0] = i[1:0];
      if (w[0]) w[23:22] = 2'h0;
      else w[20:19] = 2'h0;
      wr(w, 1'b1);
    end
    i_host.send(24'hFFFFFF, 10);
    repeat (8) @(posedge sys_clk);
    chk({12'h0, rfMainDivide}, {12'h0, w[19:8]});
    // Mux modes 1 to 7; IF locked, RF locked only in mode 2
    @(posedge sys_clk) #1 ifLocked = 1'b1;
    for (int m = 1; m < 8; m++) begin
      @(posedge sys_clk) #1 rfLocked = (m == 2);
      wr({3'h1, m[3:2], 2'h1, 15'h0003, 2'h0}, 1'b0);
      wr({3'h2, m[1:0], 2'h1, 15'h0005, 2'h2}, 1'b0);
      if (m < 5) chk({23'h0, multiplexed_test_output}, {23'h0, m != 3});
      chk({20'h0, ifDividerHold, ifPumpHighZ, rfDividerHold, rfPumpHighZ},
          {20'h0, {2{m == 5 || m == 7}}, {2{m > 5}}});
    end
    // Polarity bit set to 1 as for a positive tuning slope
    wr({3'h1, 4'h1, 15'h0003, 2'h0}, 1'b1);
    wr({3'h2, 4'h1, 15'h0005, 2'h2}, 1'b1);
    wr({2'h2, 2'h1, 12'h123, 6'h05, 2'h1}, 1'b0);
    chk({20'h0, fastlock_switch_pin_b, ifPumpCurrent}, 24'h7);
    wr({2'h2, 2'h3, 12'h0FF, 6'h11, 2'h3}, 1'b0);
    chk({20'h0, rfDampSwitch, rfPumpCurrent}, 24'hF);
    wr({2'h0, 2'h1, 12'h123, 6'h05, 2'h1}, 1'b1);
    chk({20'h0, fastlock_switch_pin_b, ifPumpCurrent}, 24'h9);
    // RF synchronous down, IF asynchronous down, then RF back up
    wr({2'h1, 2'h3, 12'h0FF, 6'h11, 2'h3}, 1'b0);
    chk({20'h0, rfDampSwitch, rfPoweredDown, rfPumpHighZ, rfDividerHold}, 24'h7);
    wr({3'h1, 4'h3, 15'h0003, 2'h0}, 1'b1);
    wr({2'h1, 2'h1, 12'h123, 6'h05, 2'h1}, 1'b0);
    chk({22'h0, ifPoweredDown, refOscEnable}, 24'h2);
    wr({2'h0, 2'h3, 12'h0FF, 6'h11, 2'h3}, 1'b1);
    chk({22'h0, rfPoweredDown, refOscEnable}, 24'h1);
    repeat (4) @(posedge sys_clk);
    end_of_test();
  end
endmodule // dual_pll_serial_latch_control_bench
`default_nettype wire

// ### verif/pll_serial_latch_asserts.sv
// Purpose: Port checks of the serial latch block
// Assumes: Outputs are registered levels on sys_clk
// Notes:   Mux modes are judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "pll_latch_defs.vh"
module pll_serial_latch_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Watched signals
  input wire logic        load_strobe,
  input wire logic [11:0] ifMainDivide,
  input wire logic [2:0]  ifPumpCurrent,
  input wire logic [2:0]  rfPumpCurrent,
  input wire logic        ifPumpHighZ,
  input wire logic        rfPumpHighZ,
  input wire logic        ifPoweredDown,
  input wire logic        rfPoweredDown,
  input wire logic        ifDividerHold,
  input wire logic        rfDividerHold,
  input wire logic        refOscEnable,
  input wire logic        fastlock_switch_pin_b,
  input wire logic        rfDampSwitch
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Reset levels, then pumps drive from empty latches
  sequence rstVals;
    ifPumpHighZ && refOscEnable && !ifPoweredDown && fastlock_switch_pin_b;
  endsequence
  sequence firstEdge;
    !ifPumpHighZ && !rfPumpHighZ && ifMainDivide == 12'h000;
  endsequence
  chk_reset_state: assert property ($rose(rst_b) |-> rstVals ##1 firstEdge)
    else $error("reset state wrong");
  chk_pump_first_if: assert property ($rose(ifPoweredDown) |-> $past(ifPumpHighZ))
    else $error("IF down before pump floated");
  chk_pump_first_rf: assert property ($rose(rfPoweredDown) |-> $past(rfPumpHighZ))
    else $error("RF down before pump floated");
  chk_pd_hold_if: assert property (ifPoweredDown [*2] |-> ifDividerHold && ifPumpHighZ)
    else $error("IF dividers not held");
  chk_pd_hold_rf: assert property (rfPoweredDown [*2] |-> rfDividerHold && rfPumpHighZ)
    else $error("RF dividers not held");
  chk_osc_both_down: assert property ((ifPoweredDown && rfPoweredDown) [*2] |-> !refOscEnable)
    else $error("oscillator left on");
  chk_fast_if: assert property (!fastlock_switch_pin_b [*2] |-> ifPumpCurrent == `CUR_MAX)
    else $error("IF fastlock current");
  chk_fast_rf: assert property (rfDampSwitch [*2] |-> rfPumpCurrent == `CUR_MAX)
    else $error("RF fastlock current");
  // Without a strobe rise the latch must not move
  chk_latch_steady: assert property (!load_strobe [*8] |-> $stable(ifMainDivide))
    else $error("latch moved without strobe");
endmodule // pll_serial_latch_asserts
bind pll_serial_latch pll_serial_latch_asserts u_chk (.*);
`default_nettype wire

// ### verif/serial_host_model.sv
// Purpose: Host driving the three-wire serial link
// Assumes: 48 ns link period, data set 12 ns before each rise
// Notes:   Link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // Link pins
  output var logic sClk,
  output var logic sData,
  output var logic strobe
);
  initial begin
    sClk = 1'b0;
    sData = 1'b0;
    strobe = 1'b0;
  end
  // Shifts nb bits; the strobe follows a whole word only
  task automatic send(input logic [23:0] w, input int nb);
    for (int i = 23; i > 23 - nb; i--) begin
      sData = w[i];
      #12 sClk = 1'b1;
      #24 sClk = 1'b0;
      #12;
    end
    if (nb == 24) begin
      strobe = 1'b1;
      #48 strobe = 1'b0;
    end
    sData = ~sData; // Released line must not show the last bit
  endtask
endmodule // serial_host_model
`default_nettype wire
